/* hdl/nvc_defines.vh */
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH

// register select codes on the processor write port
`define NVC_SEL_CONTROL 3'h0
`define NVC_SEL_KEY 3'h1
`define NVC_SEL_ADDR_LOW 3'h2
`define NVC_SEL_ADDR_HIGH 3'h3
`define NVC_SEL_DATA_LOW 3'h4
`define NVC_SEL_DATA_HIGH 3'h5

// memory_control_reg field positions
`define NVC_BIT_SPACE 7
`define NVC_BIT_ABORT 3
`define NVC_BIT_PERMIT 2
`define NVC_BIT_WRITE 1
`define NVC_BIT_READ 0

// unlock key values
`define NVC_KEY_FIRST 8'h55
`define NVC_KEY_SECOND 8'haa

// reset values
`define NVC_RESET_BYTE 8'h00
`define NVC_RESET_HIGH 6'h00

// timing
`define NVC_CLK_PERIOD_NS 10
`define NVC_CLK_PER_INSN 4
`define NVC_INSN_DIV_LAST 2'h3
`define NVC_PF_INSN_CYCLES 2'h2
`define NVC_EE_WRITE_TIME_NS 4000000
`define NVC_EE_WRITE_CYCLES (`NVC_EE_WRITE_TIME_NS / `NVC_CLK_PERIOD_NS)

`endif

/* hdl/nvc_mem.v */
`timescale 1ns/10ps
`default_nettype none

// storage for the data eeprom (256 x 8) and program flash (8k x 14)
module nvc_mem
(
   input wire clock,
   input wire ee_we,
   input wire [7:0] ee_addr,
   input wire [7:0] ee_wdata,
   output reg [7:0] ee_rdata,
   input wire pf_we,
   input wire [12:0] pf_addr,
   input wire [13:0] pf_wdata,
   output reg [13:0] pf_rdata
);

   reg [7:0] ee_array [0:255];
   reg [13:0] pf_array [0:8191];

   // synchronous read and write; the array contents are not reset
   always @(posedge clock)
   begin
      if (ee_we)
      begin
         ee_array[ee_addr] <= ee_wdata;
      end
      if (pf_we)
      begin
         pf_array[pf_addr] <= pf_wdata;
      end
      ee_rdata <= ee_array[ee_addr];
      pf_rdata <= pf_array[pf_addr];
   end

endmodule // nvc_mem

`default_nettype wire

/* hdl/nvc_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "nvc_defines.vh"

module nvc_ctrl
#(
   parameter [31:0] EE_WRITE_CYCLES = `NVC_EE_WRITE_CYCLES
)
(
   input wire CLOCK,
   input wire RESET,
   input wire WARM_RESET,
   input wire REG_WE,
   input wire [2:0] REG_SEL,
   input wire [7:0] REG_WDATA,
   input wire DONE_CLEAR,
   input wire FLASH_WRITE_ALLOW,
   input wire ADDR_PROTECTED,
   output wire [7:0] CONTROL_READ,
   output wire [7:0] KEY_READ,
   output wire [7:0] ADDR_LOW_READ,
   output wire [7:0] ADDR_HIGH_READ,
   output wire [7:0] DATA_LOW_READ,
   output wire [7:0] DATA_HIGH_READ,
   output wire [12:0] FLASH_ADDRESS,
   output wire INSN_TICK,
   output wire CPU_HALT,
   output wire BUSY,
   output reg WRITE_DONE_FLAG
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_EE_RD = 3'h1;
   localparam [2:0] ST_PF_RD = 3'h2;
   localparam [2:0] ST_EE_WR = 3'h3;
   localparam [2:0] ST_PF_WR = 3'h4;

   localparam [1:0] KEY_NONE = 2'h0;
   localparam [1:0] KEY_HALF = 2'h1;
   localparam [1:0] KEY_ARMED = 2'h2;

   reg [2:0] state;
   reg [1:0] key_state;
   reg [1:0] insn_div;
   reg [1:0] insn_count;
   reg [31:0] ee_count;
   reg [7:0] address_low_reg;
   reg [5:0] address_high_reg;
   reg [7:0] data_low_reg;
   reg [5:0] data_high_reg;
   reg program_space_select;
   reg write_abort_flag;
   reg write_permit;
   reg write_trigger;
   reg read_trigger;

   wire [7:0] ee_rdata;
   wire [13:0] pf_rdata;
   wire insn_tick;
   wire idle;
   wire ctrl_write;
   wire start_write;
   wire start_read;
   wire write_ok;
   wire write_end;

   // instruction-cycle enable: one pulse every four clocks
   assign insn_tick = (insn_div == `NVC_INSN_DIV_LAST);
   assign INSN_TICK = insn_tick;

   always @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         insn_div <= 2'h0;
      end
      else
      begin
         insn_div <= insn_div + 2'h1;
      end
   end

   assign idle = (state == ST_IDLE);
   assign ctrl_write = REG_WE && (REG_SEL == `NVC_SEL_CONTROL);
   // flash writes only where the fuse allows and the word is unprotected
   assign write_ok = !program_space_select
      || (FLASH_WRITE_ALLOW && !ADDR_PROTECTED);
   // old permit value is used, so setting both at once is refused
   assign start_write = ctrl_write && idle && REG_WDATA[`NVC_BIT_WRITE]
      && write_permit && (key_state == KEY_ARMED) && write_ok;
   assign start_read = ctrl_write && idle && REG_WDATA[`NVC_BIT_READ]
      && !start_write;

   // end of a write cycle; eeprom counts clocks, flash counts instructions
   assign write_end = ((state == ST_EE_WR) && (ee_count == 32'h0))
      || ((state == ST_PF_WR) && insn_tick
      && (insn_count == (`NVC_PF_INSN_CYCLES - 2'h1)));

   // unlock key tracker; the key port itself keeps no value
   always @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         key_state <= KEY_NONE;
      end
      else if (WARM_RESET)
      begin
         key_state <= KEY_NONE;
      end
      else if (REG_WE)
      begin
         if (REG_SEL == `NVC_SEL_KEY)
         begin
            if (REG_WDATA == `NVC_KEY_FIRST)
            begin
               key_state <= KEY_HALF;
            end
            else if ((REG_WDATA == `NVC_KEY_SECOND) && (key_state == KEY_HALF))
            begin
               key_state <= KEY_ARMED;
            end
            else
            begin
               key_state <= KEY_NONE;
            end
         end
         else
         begin
            // every other write, trigger included, uses up or breaks the key
            key_state <= KEY_NONE;
         end
      end
   end

   // control register, sequencer and data path
   always @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         state <= ST_IDLE;
         insn_count <= 2'h0;
         ee_count <= 32'h0;
         address_low_reg <= `NVC_RESET_BYTE;
         address_high_reg <= `NVC_RESET_HIGH;
         data_low_reg <= `NVC_RESET_BYTE;
         data_high_reg <= `NVC_RESET_HIGH;
         program_space_select <= 1'b0;
         write_abort_flag <= 1'b0;
         write_permit <= 1'b0;
         write_trigger <= 1'b0;
         read_trigger <= 1'b0;
      end
      else if (WARM_RESET)
      begin
         // address, data and select survive; an interrupted write is flagged
         if ((state == ST_EE_WR) || (state == ST_PF_WR))
         begin
            write_abort_flag <= 1'b1;
         end
         state <= ST_IDLE;
         insn_count <= 2'h0;
         write_permit <= 1'b0;
         write_trigger <= 1'b0;
         read_trigger <= 1'b0;
      end
      else
      begin
         if (REG_WE && idle)
         begin
            case (REG_SEL)
               `NVC_SEL_ADDR_LOW: address_low_reg <= REG_WDATA;
               `NVC_SEL_ADDR_HIGH: address_high_reg <= REG_WDATA[5:0];
               `NVC_SEL_DATA_LOW: data_low_reg <= REG_WDATA;
               `NVC_SEL_DATA_HIGH: data_high_reg <= REG_WDATA[5:0];
               `NVC_SEL_CONTROL: program_space_select <= REG_WDATA[`NVC_BIT_SPACE];
               default: address_low_reg <= address_low_reg;
            endcase
         end
         // permit and abort stay writable during a cycle; the cycle ignores them
         if (ctrl_write)
         begin
            write_permit <= REG_WDATA[`NVC_BIT_PERMIT];
            write_abort_flag <= REG_WDATA[`NVC_BIT_ABORT];
         end
         case (state)
            ST_IDLE:
            begin
               insn_count <= 2'h0;
               if (start_write)
               begin
                  write_trigger <= 1'b1;
                  ee_count <= EE_WRITE_CYCLES - 32'h1;
                  state <= program_space_select ? ST_PF_WR : ST_EE_WR;
               end
               else if (start_read)
               begin
                  read_trigger <= 1'b1;
                  state <= program_space_select ? ST_PF_RD : ST_EE_RD;
               end
            end
            ST_EE_RD:
            begin
               // array answered one clock after the trigger, well inside one instruction
               data_low_reg <= ee_rdata;
               read_trigger <= 1'b0;
               state <= ST_IDLE;
            end
            ST_PF_RD:
            begin
               if (insn_tick)
               begin
                  insn_count <= insn_count + 2'h1;
                  if (insn_count == (`NVC_PF_INSN_CYCLES - 2'h1))
                  begin
                     data_low_reg <= pf_rdata[7:0];
                     data_high_reg <= pf_rdata[13:8];
                     read_trigger <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_EE_WR:
            begin
               ee_count <= ee_count - 32'h1;
               if (write_end)
               begin
                  write_trigger <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_PF_WR:
            begin
               if (insn_tick)
               begin
                  insn_count <= insn_count + 2'h1;
               end
               if (write_end)
               begin
                  write_trigger <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // done flag: hardware set beats a software clear in the same cycle
   always @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         WRITE_DONE_FLAG <= 1'b0;
      end
      else if (write_end && !WARM_RESET)
      begin
         WRITE_DONE_FLAG <= 1'b1;
      end
      else if (DONE_CLEAR)
      begin
         WRITE_DONE_FLAG <= 1'b0;
      end
   end

   // halt only stops instruction issue; this block and its clock keep going
   assign CPU_HALT = (state == ST_PF_WR);
   assign BUSY = !idle;

   assign CONTROL_READ = {program_space_select, 3'h0, write_abort_flag,
      write_permit, write_trigger, read_trigger};
   assign KEY_READ = 8'h00;
   assign ADDR_LOW_READ = address_low_reg;
   assign ADDR_HIGH_READ = {2'h0, address_high_reg};
   assign DATA_LOW_READ = data_low_reg;
   assign DATA_HIGH_READ = {2'h0, data_high_reg};
   assign FLASH_ADDRESS = {address_high_reg[4:0], address_low_reg};

   // array is written at the start of the cycle; the cycle then times it
   nvc_mem u_mem
   (
      .clock(CLOCK),
      .ee_we(start_write && !program_space_select),
      .ee_addr(address_low_reg),
      .ee_wdata(data_low_reg),
      .ee_rdata(ee_rdata),
      .pf_we(start_write && program_space_select),
      .pf_addr({address_high_reg[4:0], address_low_reg}),
      .pf_wdata({data_high_reg, data_low_reg}),
      .pf_rdata(pf_rdata)
   );

endmodule // nvc_ctrl

`default_nettype wire

/* dv/nvc_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// port checks; all are held off while power-on reset is high
module nvc_ctrl_asserts (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic WARM_RESET,
   input wire logic REG_WE,
   input wire logic [2:0] REG_SEL,
   input wire logic [7:0] REG_WDATA,
   input wire logic DONE_CLEAR,
   input wire logic [7:0] CONTROL_READ,
   input wire logic [7:0] KEY_READ,
   input wire logic INSN_TICK,
   input wire logic CPU_HALT,
   input wire logic BUSY,
   input wire logic WRITE_DONE_FLAG
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // a processor write to the control register
   wire logic ctl_we = REG_WE && REG_SEL == 3'h0;
   a_key_reads_zero: assert property (KEY_READ == 8'h00)
      else $error("key port not zero");
   a_permit_kept: assert property ($fell(CONTROL_READ[2]) |->
      $past(ctl_we && !REG_WDATA[2] || WARM_RESET)) else $error("permit lost");
   a_trig_needs_permit: assert property ($rose(CONTROL_READ[1]) |->
      $past(CONTROL_READ[2])) else $error("trigger without permit");
   a_trig_from_write: assert property ($rose(CONTROL_READ[1]) |->
      $past(ctl_we && REG_WDATA[1])) else $error("trigger without write");
   a_done_on_finish: assert property ($fell(CONTROL_READ[1]) && !$past(WARM_RESET)
      |-> WRITE_DONE_FLAG) else $error("no done flag");
   a_done_sticky: assert property (WRITE_DONE_FLAG && !DONE_CLEAR |=> WRITE_DONE_FLAG)
      else $error("done flag dropped");
   a_halt_two_insn: assert property ($rose(CPU_HALT) |->
      CPU_HALT[*5] ##[1:4] !CPU_HALT) else $error("halt length");
   a_clock_runs: assert property (CPU_HALT |-> ##[0:3] INSN_TICK)
      else $error("ticks stopped in halt");
   a_ee_read_fast: assert property (ctl_we && !BUSY && REG_WDATA[7] == 1'b0 &&
      REG_WDATA[1:0] == 2'h1 |=> ##1 !CONTROL_READ[0] && !BUSY) else $error("ee read slow");
   a_flash_read_len: assert property ($rose(CONTROL_READ[0]) && CONTROL_READ[7] |->
      ##[1:8] !CONTROL_READ[0]) else $error("flash read slow");
   c_halt: cover property ($rose(CPU_HALT));
   c_done: cover property ($rose(WRITE_DONE_FLAG));
   c_read: cover property ($fell(CONTROL_READ[0]));
endmodule // nvc_ctrl_asserts
bind nvc_ctrl nvc_ctrl_asserts chk_u (.CLOCK, .RESET, .WARM_RESET, .REG_WE, .REG_SEL,
   .REG_WDATA, .DONE_CLEAR, .CONTROL_READ, .KEY_READ, .INSN_TICK, .CPU_HALT, .BUSY,
   .WRITE_DONE_FLAG);
`default_nettype wire

/* dv/nvc_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// processor side: one register write per wr call, three per unlock call
module nvc_cpu_model (
   input wire logic clk,
   input wire logic halt,
   output logic we,
   output logic [2:0] sel,
   output logic [7:0] wd
);
   // halts that outlast the wait bound; the bench adds them to its mismatches
   integer n_stuck = 0;
   initial
   begin
      we = 1'b0;
      sel = 3'h0;
      wd = 8'h00;
   end
   // a halt is waited out for up to 16 clocks, then the write issues anyway; released data is inverted so stale values never match
   task wr(input logic [2:0] s, input logic [7:0] d);
      integer n;
      begin
         @(posedge clk);
         // a halt lasts a handful of clocks; a longer one is counted, not waited out
         for (n = 0; n < 16 && halt; n++)
            @(posedge clk);
         if (halt)
         begin
            n_stuck++;
            $display("[ERR] %0t halt stuck", $time);
         end
         we <= 1'b1;
         sel <= s;
         wd <= d;
         @(posedge clk);
         we <= 1'b0;
         wd <= ~d;
         #1;
      end
   endtask
   // interrupts never reach this model, so the sequence cannot be split
   task unlock(input logic [7:0] ctl);
      begin
         wr(3'h1, 8'h55);
         wr(3'h1, 8'haa);
         wr(3'h0, ctl);
      end
   endtask
endmodule // nvc_cpu_model
`default_nettype wire

/* dv/nvc_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module nvc_ctrl_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic warm = 1'b0;
   logic dclr = 1'b0;
   logic allow = 1'b1;
   logic prot = 1'b0;
   wire logic we, halt, busy, done;
   wire logic [2:0] sel;
   wire logic tick;
   wire logic [7:0] wd, ctl, key, alo, ahi, dlo, dhi;
   wire logic [12:0] faddr;
   integer n_mismatch = 0;
   integer tests_run = 0;
   // short write time keeps the run brief
   always #5 clk = ~clk;
   nvc_ctrl #(.EE_WRITE_CYCLES(20)) dut_u (.CLOCK(clk), .RESET(rst), .WARM_RESET(warm),
      .REG_WE(we), .REG_SEL(sel), .REG_WDATA(wd), .DONE_CLEAR(dclr),
      .FLASH_WRITE_ALLOW(allow), .ADDR_PROTECTED(prot), .CONTROL_READ(ctl), .KEY_READ(key),
      .ADDR_LOW_READ(alo), .ADDR_HIGH_READ(ahi), .DATA_LOW_READ(dlo), .DATA_HIGH_READ(dhi),
      .FLASH_ADDRESS(faddr), .INSN_TICK(tick), .CPU_HALT(halt), .BUSY(busy),
      .WRITE_DONE_FLAG(done));
   nvc_cpu_model cpu_u (.clk(clk), .halt(halt), .we(we), .sel(sel), .wd(wd));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      begin
         tests_run++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         n_mismatch = n_mismatch + cpu_u.n_stuck;
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // a stuck busy ends the run rather than hanging it
   task wait_idle;
      integer i;
      begin
         for (i = 0; i < 100 && busy !== 1'b0; i++)
            @(posedge clk) #1;
         if (busy !== 1'b0)
         begin
            n_mismatch++;
            $display("[ERR] %0t busy stuck", $time);
            report_and_stop;
         end
      end
   endtask
   task t_ee_write;
      begin
         cpu_u.wr(3'h2, 8'h10);
         cpu_u.wr(3'h4, 8'h5a);
         cpu_u.wr(3'h0, 8'h04);
         cpu_u.unlock(8'h06);
         chk(ctl, 8'h06);
         cpu_u.wr(3'h0, 8'h00);
         chk(ctl, 8'h02);
         wait_idle;
         chk({ctl[1], done}, 8'h01);
         @(posedge clk) dclr <= 1'b1;
         @(posedge clk) dclr <= 1'b0;
         #1;
         chk(done, 8'h00);
         // overwrite the data byte so that only a real read brings it back
         cpu_u.wr(3'h4, 8'h00);
         cpu_u.wr(3'h0, 8'h01);
         @(posedge clk) #1;
         chk(dlo, 8'h5a);
         $display("test ee_write done");
      end
   endtask
   task t_broken;
      begin
         cpu_u.wr(3'h0, 8'h04);
         cpu_u.wr(3'h1, 8'h55);
         cpu_u.wr(3'h2, 8'h11);
         cpu_u.wr(3'h1, 8'haa);
         cpu_u.wr(3'h0, 8'h06);
         chk(ctl, 8'h04);
         cpu_u.wr(3'h0, 8'h00);
         cpu_u.unlock(8'h06);
         chk(ctl, 8'h04);
         chk(key, 8'h00);
         cpu_u.wr(3'h0, 8'h00);
         $display("test broken done");
      end
   endtask
   task t_flash;
      logic [15:0] n_tick;
      begin
         cpu_u.wr(3'h3, 8'h01);
         cpu_u.wr(3'h2, 8'h23);
         cpu_u.wr(3'h5, 8'h15);
         cpu_u.wr(3'h4, 8'h67);
         cpu_u.wr(3'h0, 8'h84);
         cpu_u.unlock(8'h86);
         chk(halt, 8'h01);
         n_tick = 16'h0;
         // instruction ticks keep coming while the cpu is halted
         repeat (4)
         begin
            @(posedge clk) #1;
            n_tick = n_tick + {15'h0, tick};
         end
         chk(n_tick, 16'h1);
         chk(halt, 8'h01);
         wait_idle;
         chk(done, 8'h01);
         chk(ahi, 8'h01);
         chk(faddr, 16'h0123);
         // clear both data bytes so that only the read can restore them
         cpu_u.wr(3'h4, 8'h00);
         cpu_u.wr(3'h5, 8'h00);
         cpu_u.wr(3'h0, 8'h81);
         wait_idle;
         chk(dlo, 8'h67);
         chk(dhi, 8'h15);
         repeat (2)
         begin
            @(posedge clk);
            // first pass fuse off and word protected, second pass word protected only
            allow <= prot;
            prot <= 1'b1;
            cpu_u.wr(3'h0, 8'h84);
            cpu_u.unlock(8'h86);
            chk({halt, ctl[1]}, 8'h00);
         end
         @(posedge clk) prot <= 1'b0;
         $display("test flash done");
      end
   endtask
   task t_warm;
      begin
         cpu_u.wr(3'h0, 8'h04);
         cpu_u.unlock(8'h06);
         @(posedge clk) warm <= 1'b1;
         @(posedge clk) warm <= 1'b0;
         #1;
         chk(ctl, 8'h08);
         chk(alo, 8'h23);
         chk(dlo, 8'h67);
         $display("test warm done");
      end
   endtask
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_ee_write;
      t_broken;
      t_flash;
      t_warm;
      report_and_stop;
   end
endmodule // nvc_ctrl_tb
`default_nettype wire
